// File: common/port_power_regs.vh
// Constants for the downstream port power and overcurrent pin block
`ifndef PORT_POWER_REGS_VH
`define PORT_POWER_REGS_VH
`define PORT_COUNT        6
`define SPLIT_PORT_COUNT  3
`define GPIO_COUNT        4
`define GPIO_FIRST_NUMBER 70
`define OC_EVENT_RESET    6'h00
`define PORT_EN_RESET     6'h00
`define GPIO_OUT_RESET    4'h0
`define GPIO_OE_RESET     4'h0
`define SS_EN_RESET       3'h0
`define PIN_OUT_RESET     6'h00
`define PIN_OE_RESET      6'h3F
`define PIN_PULLUP_RESET  6'h00
`define OC_ACTIVE_RESET   6'h00
`define POWERED_RESET     6'h00
`endif

// File: logic/port_power_oc_pins.v
// Downstream port power enable, overcurrent sense, split enables and spare I/O
//
// Summary of operation
// - Enabled port: shared pin is an input with pull-up switched on.
// - The pull-up level itself requests power from the external switch.
// - Enabled port senses its shared pin low as overcurrent.
// - Disabled port: pin becomes an output driven low, removing power.
// - Ports 1, 5, 6: one pin powers both USB 2.0 and 3.2 halves.
// - Ports 2-4 unsplit: shared pin powers both halves.
// - Ports 2-4 split: shared pin powers only the USB 2.0 half.
// - Split on: separate active-high enable powers the USB 3.2 half.
// - Split off: the separate enables carry no function, held low.
// - Four general I/O functions 70-73, each software input or output.
`include "port_power_regs.vh"

module port_power_oc_pins
(
  input  wire       i_clock,
  input  wire       i_rst_n,
  input  wire [5:0] i_port_enable,
  input  wire [2:0] i_split_port_mode,
  input  wire [2:0] i_ss_power_request,
  input  wire [5:0] i_oc_event_clear,
  input  wire [5:0] i_power_oc_pin_in,
  input  wire [3:0] i_gpio_out,
  input  wire [3:0] i_gpio_oe,
  input  wire [3:0] i_general_io_pin_in,
  output reg  [5:0] o_power_oc_pin_out,
  output reg  [5:0] o_power_oc_pin_oe,
  output reg  [5:0] o_power_oc_pin_pullup,
  output reg  [2:0] o_superspeed_power_en,
  output reg  [5:0] o_oc_active,
  output reg  [5:0] o_oc_event,
  output reg  [5:0] o_port_powered_hs,
  output reg  [5:0] o_port_powered_ss,
  output reg  [3:0] o_general_io_pin_out,
  output reg  [3:0] o_general_io_pin_oe,
  output reg  [3:0] o_general_io_pin_read
);

  // Bit n of each 6-bit group is port n+1; split bits 0..2 are ports 2..4
  // Next value of each per-port register but the pin output level, worked out by one slice per port
  wire [5:0] pin_oe_nxt;
  wire [5:0] pin_pullup_nxt;
  wire [5:0] oc_active_nxt;
  wire [5:0] oc_event_nxt;
  wire [5:0] powered_hs_nxt;
  wire [5:0] powered_ss_nxt;
  wire [2:0] ss_power_en_nxt;

  // Only ports 2 to 4 may split; the other slices tie their split inputs off

  // Port 1: one pin governs both halves, no split option
  port_pin_slice #(.HAS_SPLIT(0)) port1_slice
  (
    .i_enable      (i_port_enable[0]),
    .i_split       (1'b0),
    .i_ss_request  (1'b0),
    .i_event_clear (i_oc_event_clear[0]),
    .i_pin_in      (i_power_oc_pin_in[0]),
    .i_pin_oe_now  (o_power_oc_pin_oe[0]),
    .i_pullup_now  (o_power_oc_pin_pullup[0]),
    .i_event_now   (o_oc_event[0]),
    .o_pin_oe_nxt  (pin_oe_nxt[0]),
    .o_pullup_nxt  (pin_pullup_nxt[0]),
    .o_active_nxt  (oc_active_nxt[0]),
    .o_event_nxt   (oc_event_nxt[0]),
    .o_hs_nxt      (powered_hs_nxt[0]),
    .o_ss_nxt      (powered_ss_nxt[0]),
    .o_ss_en_nxt   ()
  );

  // Port 2: may split, its USB 3.2 enable is split bit 0
  port_pin_slice #(.HAS_SPLIT(1)) port2_slice
  (
    .i_enable      (i_port_enable[1]),
    .i_split       (i_split_port_mode[0]),
    .i_ss_request  (i_ss_power_request[0]),
    .i_event_clear (i_oc_event_clear[1]),
    .i_pin_in      (i_power_oc_pin_in[1]),
    .i_pin_oe_now  (o_power_oc_pin_oe[1]),
    .i_pullup_now  (o_power_oc_pin_pullup[1]),
    .i_event_now   (o_oc_event[1]),
    .o_pin_oe_nxt  (pin_oe_nxt[1]),
    .o_pullup_nxt  (pin_pullup_nxt[1]),
    .o_active_nxt  (oc_active_nxt[1]),
    .o_event_nxt   (oc_event_nxt[1]),
    .o_hs_nxt      (powered_hs_nxt[1]),
    .o_ss_nxt      (powered_ss_nxt[1]),
    .o_ss_en_nxt   (ss_power_en_nxt[0])
  );

  // Port 3: may split, its USB 3.2 enable is split bit 1
  port_pin_slice #(.HAS_SPLIT(1)) port3_slice
  (
    .i_enable      (i_port_enable[2]),
    .i_split       (i_split_port_mode[1]),
    .i_ss_request  (i_ss_power_request[1]),
    .i_event_clear (i_oc_event_clear[2]),
    .i_pin_in      (i_power_oc_pin_in[2]),
    .i_pin_oe_now  (o_power_oc_pin_oe[2]),
    .i_pullup_now  (o_power_oc_pin_pullup[2]),
    .i_event_now   (o_oc_event[2]),
    .o_pin_oe_nxt  (pin_oe_nxt[2]),
    .o_pullup_nxt  (pin_pullup_nxt[2]),
    .o_active_nxt  (oc_active_nxt[2]),
    .o_event_nxt   (oc_event_nxt[2]),
    .o_hs_nxt      (powered_hs_nxt[2]),
    .o_ss_nxt      (powered_ss_nxt[2]),
    .o_ss_en_nxt   (ss_power_en_nxt[1])
  );

  // Port 4: may split, its USB 3.2 enable is split bit 2
  port_pin_slice #(.HAS_SPLIT(1)) port4_slice
  (
    .i_enable      (i_port_enable[3]),
    .i_split       (i_split_port_mode[2]),
    .i_ss_request  (i_ss_power_request[2]),
    .i_event_clear (i_oc_event_clear[3]),
    .i_pin_in      (i_power_oc_pin_in[3]),
    .i_pin_oe_now  (o_power_oc_pin_oe[3]),
    .i_pullup_now  (o_power_oc_pin_pullup[3]),
    .i_event_now   (o_oc_event[3]),
    .o_pin_oe_nxt  (pin_oe_nxt[3]),
    .o_pullup_nxt  (pin_pullup_nxt[3]),
    .o_active_nxt  (oc_active_nxt[3]),
    .o_event_nxt   (oc_event_nxt[3]),
    .o_hs_nxt      (powered_hs_nxt[3]),
    .o_ss_nxt      (powered_ss_nxt[3]),
    .o_ss_en_nxt   (ss_power_en_nxt[2])
  );

  // Port 5: one pin governs both halves, no split option
  port_pin_slice #(.HAS_SPLIT(0)) port5_slice
  (
    .i_enable      (i_port_enable[4]),
    .i_split       (1'b0),
    .i_ss_request  (1'b0),
    .i_event_clear (i_oc_event_clear[4]),
    .i_pin_in      (i_power_oc_pin_in[4]),
    .i_pin_oe_now  (o_power_oc_pin_oe[4]),
    .i_pullup_now  (o_power_oc_pin_pullup[4]),
    .i_event_now   (o_oc_event[4]),
    .o_pin_oe_nxt  (pin_oe_nxt[4]),
    .o_pullup_nxt  (pin_pullup_nxt[4]),
    .o_active_nxt  (oc_active_nxt[4]),
    .o_event_nxt   (oc_event_nxt[4]),
    .o_hs_nxt      (powered_hs_nxt[4]),
    .o_ss_nxt      (powered_ss_nxt[4]),
    .o_ss_en_nxt   ()
  );

  // Port 6: one pin governs both halves, no split option
  port_pin_slice #(.HAS_SPLIT(0)) port6_slice
  (
    .i_enable      (i_port_enable[5]),
    .i_split       (1'b0),
    .i_ss_request  (1'b0),
    .i_event_clear (i_oc_event_clear[5]),
    .i_pin_in      (i_power_oc_pin_in[5]),
    .i_pin_oe_now  (o_power_oc_pin_oe[5]),
    .i_pullup_now  (o_power_oc_pin_pullup[5]),
    .i_event_now   (o_oc_event[5]),
    .o_pin_oe_nxt  (pin_oe_nxt[5]),
    .o_pullup_nxt  (pin_pullup_nxt[5]),
    .o_active_nxt  (oc_active_nxt[5]),
    .o_event_nxt   (oc_event_nxt[5]),
    .o_hs_nxt      (powered_hs_nxt[5]),
    .o_ss_nxt      (powered_ss_nxt[5]),
    .o_ss_en_nxt   ()
  );

  // Shared pin direction; reset keeps every port unpowered until enabled
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_power_oc_pin_out    <= `PIN_OUT_RESET;
      o_power_oc_pin_oe     <= `PIN_OE_RESET;
      o_power_oc_pin_pullup <= `PIN_PULLUP_RESET;
    end
    else
    begin
      o_power_oc_pin_out    <= 6'h00;
      o_power_oc_pin_oe     <= pin_oe_nxt;
      o_power_oc_pin_pullup <= pin_pullup_nxt;
    end
  end

  // Power state per half, as reported by the slices
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_port_powered_hs <= `POWERED_RESET;
      o_port_powered_ss <= `POWERED_RESET;
    end
    else
    begin
      o_port_powered_hs <= powered_hs_nxt;
      o_port_powered_ss <= powered_ss_nxt;
    end
  end

  // Split enables stay low when split is off, so nothing rides on them
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_superspeed_power_en <= `SS_EN_RESET;
    else
      o_superspeed_power_en <= ss_power_en_nxt;
  end

  // Sticky overcurrent events; a new event beats a clear in the same cycle
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_oc_event  <= `OC_EVENT_RESET;
      o_oc_active <= `OC_ACTIVE_RESET;
    end
    else
    begin
      o_oc_event  <= oc_event_nxt;
      o_oc_active <= oc_active_nxt;
    end
  end

  // General I/O: software picks direction per pin, input always readable
  always @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_general_io_pin_out  <= `GPIO_OUT_RESET;
      o_general_io_pin_oe   <= `GPIO_OE_RESET;
      o_general_io_pin_read <= 4'h0;
    end
    else
    begin
      o_general_io_pin_out  <= i_gpio_out;
      o_general_io_pin_oe   <= i_gpio_oe;
      o_general_io_pin_read <= i_general_io_pin_in;
    end
  end

endmodule // port_power_oc_pins

// Next-value logic for one shared power / overcurrent pin and its port.
// HAS_SPLIT marks the ports whose USB 3.2 half may take its own enable.
// The slice holds no state: the top keeps every register so outputs stay flops.
module port_pin_slice
#(
  parameter HAS_SPLIT = 0
)
(
  input  wire i_enable,
  input  wire i_split,
  input  wire i_ss_request,
  input  wire i_event_clear,
  input  wire i_pin_in,
  input  wire i_pin_oe_now,
  input  wire i_pullup_now,
  input  wire i_event_now,
  output wire o_pin_oe_nxt,
  output wire o_pullup_nxt,
  output wire o_active_nxt,
  output wire o_event_nxt,
  output wire o_hs_nxt,
  output wire o_ss_nxt,
  output wire o_ss_en_nxt
);

  wire split_on;
  wire released;
  wire oc_seen;
  wire power_granted;

  // Split is forced off on ports that have no separate USB 3.2 enable
  assign split_on = (HAS_SPLIT != 0) & i_split;

  // Enabled ports release the pin onto the pull-up; disabled ports pull it low
  assign o_pin_oe_nxt = ~i_enable;
  assign o_pullup_nxt = i_enable;

  // Only a released, pulled-up pin is sensed, so our own low drive never
  // reads back as overcurrent; using the registered direction costs one
  // cycle of latency but keeps the sense from racing the direction change
  assign released = i_pullup_now & ~i_pin_oe_now;
  assign oc_seen  = released & ~i_pin_in & i_enable;

  // A high pin while released means the external switch holds power on
  assign power_granted = released & i_pin_in & i_enable;

  // Current overcurrent level and the sticky event; set beats clear
  assign o_active_nxt = oc_seen;
  assign o_event_nxt  = (i_event_now & ~i_event_clear) | oc_seen;

  // The USB 2.0 half always follows the shared pin
  assign o_hs_nxt = power_granted;

  // The USB 3.2 half follows the pin unless split, then its own request
  assign o_ss_nxt = split_on ? (i_ss_request & i_enable) : power_granted;

  // The separate enable is low whenever split is off, so it carries nothing
  assign o_ss_en_nxt = split_on & i_ss_request & i_enable;

endmodule // port_pin_slice

// File: verif/port_power_oc_pins_props.sv
// Checker for the port power pin block
module port_power_oc_pins_props (
  input wire logic       i_clock, i_rst_n,
  input wire logic [5:0] i_port_enable, i_power_oc_pin_in, i_oc_event_clear, o_power_oc_pin_oe,
  input wire logic [5:0] o_power_oc_pin_pullup, o_oc_active, o_oc_event, o_port_powered_hs,
  input wire logic [5:0] o_port_powered_ss,
  input wire logic [2:0] i_split_port_mode, i_ss_power_request, o_superspeed_power_en
);
  timeunit 1ns; timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_pullup_on: assert property (
    1 |=> o_power_oc_pin_pullup == $past(i_port_enable)) else $error("pullup");
  chk_drive_low: assert property (
    1 |=> o_power_oc_pin_oe == ~$past(i_port_enable)) else $error("drive");
  chk_oc_sense: assert property (
    1 |=> o_oc_active == $past(o_power_oc_pin_pullup & ~o_power_oc_pin_oe & ~i_power_oc_pin_in
                               & i_port_enable))
    else $error("sense");
  chk_event_set: assert property ((o_oc_active & ~o_oc_event) == 6'h00) else $error("set");
  chk_event_hold: assert property (
    1 |=> ($past(o_oc_event & ~i_oc_event_clear) & ~o_oc_event) == 6'h00) else $error("hold");
  chk_split_en: assert property (
    1 |=> o_superspeed_power_en ==
          $past(i_split_port_mode & i_ss_power_request & i_port_enable[3:1]))
    else $error("split");
  chk_split_off_low: assert property (
    i_split_port_mode == 3'h0 |=> o_superspeed_power_en == 3'h0) else $error("split off");
  chk_hs_follows: assert property (
    1 |=> o_port_powered_hs == $past(o_power_oc_pin_pullup & ~o_power_oc_pin_oe
                                     & i_power_oc_pin_in & i_port_enable)) else $error("hs");
  chk_whole_port: assert property (
    (o_port_powered_ss & 6'h31) == (o_port_powered_hs & 6'h31)) else $error("whole");
  chk_unsplit_ss: assert property (
    i_split_port_mode == 3'h0 |=> o_port_powered_ss[3:1] == o_port_powered_hs[3:1]) else $error("ss");
  cover property (o_oc_event != 6'h00);
  cover property (o_superspeed_power_en != 3'h0);
  cover property (o_power_oc_pin_oe == 6'h01);
  cover property (o_oc_active != 6'h00 && i_oc_event_clear != 6'h00);
endmodule // port_power_oc_pins_props
bind port_power_oc_pins port_power_oc_pins_props chk (.*);

// File: verif/power_switch_model.sv
// External power switch and current monitor on the shared pins
module power_switch_model (
  input  wire logic [5:0] i_oe, i_out, i_pullup, i_fault,
  input  wire logic [2:0] i_ss_en,
  output wire logic [5:0] o_pin,
  output wire logic [2:0] o_embedded_on
);
  timeunit 1ns; timeprecision 100ps;
  // Monitor sinks the pulled-up line on a fault; a driven pin wins, so a
  // disabled port's pin needs nothing outside and reads low whatever the fault
  assign o_pin = (i_oe & i_out) | (~i_oe & i_pullup & ~i_fault);
  // Split enables power only an embedded USB 3.2 load, never a connector
  assign o_embedded_on = i_ss_en;
endmodule // power_switch_model

// File: verif/port_power_oc_pins_test.sv
// Self-checking bench for the port power pin block
module port_power_oc_pins_test;
  timeunit 1ns; timeprecision 100ps;
  logic clk = 0, rst_n = 0;
  logic [5:0] en = 0, clr = 0, flt = 0, pin, oe, out, pu, act, ev, hs, ss;
  logic [2:0] spl = 0, req = 0, sse, emb;
  logic [3:0] go = 0, goe = 0, gr, gout, gdir;
  int error_cnt = 0, n_checks = 0;
  always #2 clk = ~clk;
  port_power_oc_pins DUT (.i_clock(clk), .i_rst_n(rst_n), .i_port_enable(en), .i_split_port_mode(spl),
    .i_ss_power_request(req), .i_oc_event_clear(clr), .i_power_oc_pin_in(pin), .i_gpio_out(go),
    .i_gpio_oe(goe), .i_general_io_pin_in(go), .o_power_oc_pin_out(out), .o_power_oc_pin_oe(oe),
    .o_power_oc_pin_pullup(pu), .o_superspeed_power_en(sse), .o_oc_active(act), .o_oc_event(ev),
    .o_port_powered_hs(hs), .o_port_powered_ss(ss), .o_general_io_pin_out(gout),
    .o_general_io_pin_oe(gdir), .o_general_io_pin_read(gr));
  power_switch_model PSW (.i_oe(oe), .i_out(out), .i_pullup(pu), .i_fault(flt),
    .i_ss_en(sse), .o_pin(pin), .o_embedded_on(emb));
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, when outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #1000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    step(20); rst_n = 1; step(1);
    chk(oe, 6'h3F);
    en = 6'h3F; step(2);
    chk(pu, 6'h3F);
    chk(hs & ss, 6'h3F);
    flt = 6'h04; step(1);
    chk(act & ev, 6'h04);
    clr = 6'h04; step(1);
    chk(ev, 6'h04);
    flt = 6'h00; step(1); clr = 6'h00;
    chk(ev, 6'h00);
    spl = 3'h7; req = 3'h5; step(1);
    chk({3'h0, sse}, 6'h05);
    chk(ss, 6'h3B);
    chk(hs, 6'h3F);
    chk({3'h0, emb}, 6'h05);
    spl = 3'h0; step(1);
    chk({3'h0, sse}, 6'h00);
    en = 6'h3E; step(1); flt = 6'h01; step(2);
    chk(oe | act | ev, 6'h01);
    chk(out, 6'h00);
    chk(ss, 6'h3E);
    go = 4'hA;
    goe = 4'h5;
    step(1);
    chk({2'h0, gr}, 6'h0A);
    chk({2'h0, gout}, 6'h0A);
    chk({2'h0, gdir}, 6'h05);
    // Mid-run reset: every port drops to driven low, then ports 2-6 come back
    rst_n = 0;
    step(1);
    chk(oe, 6'h3F);
    chk(pu | hs | ss | ev, 6'h00);
    chk({2'h0, gout | gdir}, 6'h00);
    rst_n = 1;
    step(2);
    chk(pu & hs, 6'h3E);
    tally_and_finish;
  end
endmodule // port_power_oc_pins_test
